//--- rtl/mmmac_core.sv
`timescale 1ns/1ps
module mmmac_core
  import mmmac_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Peripheral bus access
  input  wire mmmac_bus_t  bus,
  // Read data and result status
  output logic [15:0]      rdata,
  output logic             busy
);

  // Operand, mode and result state
  logic [15:0] opa_reg, opa_next;          // Stored first operand
  logic [15:0] opb_reg, opb_next;          // Stored second operand
  mmmac_mode_t mode_reg, mode_next;        // Latched operation
  logic [15:0] lo_reg, lo_next;            // Result low word
  logic [15:0] hi_reg, hi_next;            // Result high word
  logic [15:0] ext_reg, ext_next;          // Result extension word
  logic        start_reg, start_next;      // Computation pending
  logic [15:0] rdata_reg, rdata_next;      // Registered read data

  // Product and sum terms
  logic        sgn;                        // Signed operation
  logic [32:0] prod;                       // 33-bit signed product
  logic [32:0] acc;                        // Held result, extended
  logic [32:0] sum;                        // Accumulated value
  logic        acc_mode;                   // Accumulate operation

  // Written word, masked to low byte on byte writes
  logic [15:0] wval;

  always_comb begin
    // Byte writes zero-extend; sign extension is software's job
    if (bus.byte_acc) begin
      wval = {8'h00, bus.wdata[BYTE_W-1:0]};
    end else begin
      wval = bus.wdata;
    end
  end

  // Datapath: one clock of compute, well inside the budget
  always_comb begin
    sgn = (mode_reg == signed_product_mode) ||
          (mode_reg == signed_accumulate_mode);
    acc_mode = (mode_reg == unsigned_accumulate_mode) ||
               (mode_reg == signed_accumulate_mode);
    if (sgn) begin
      prod = 33'($signed({opa_reg[SIGN_BIT], opa_reg}) *
                 $signed({opb_reg[SIGN_BIT], opb_reg}));
    end else begin
      prod = 33'({1'b0, opa_reg} * {1'b0, opb_reg});
    end
    // Held result extended by mode: carry-free for unsigned
    if (sgn) begin
      acc = {hi_reg[SIGN_BIT], hi_reg, lo_reg};
    end else begin
      acc = {1'b0, hi_reg, lo_reg};
    end
    // Wraps in 32 bits; bit 32 keeps the true sign or carry
    sum = acc_mode ? (acc + prod) : prod;
  end

  // Next-state for registers and bus
  always_comb begin
    opa_next   = opa_reg;
    opb_next   = opb_reg;
    mode_next  = mode_reg;
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    ext_next   = ext_reg;
    start_next = 1'b0;
    rdata_next = rdata_reg;
    // Finish the pending operation one clock after trigger
    if (start_reg) begin
      lo_next = sum[15:0];
      hi_next = sum[31:16];
      unique case (mode_reg)
        unsigned_product_mode: begin
          ext_next = EXT_ZERO;
        end
        unsigned_accumulate_mode: begin
          ext_next = sum[32] ? EXT_CARRY : EXT_ZERO;
        end
        signed_product_mode, signed_accumulate_mode: begin
          ext_next = sum[32] ? EXT_ONES : EXT_ZERO;
        end
      endcase
    end
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_OPA_UMUL: begin
          opa_next  = wval;
          mode_next = unsigned_product_mode;
        end
        ADDR_OPA_SMUL: begin
          opa_next  = wval;
          mode_next = signed_product_mode;
        end
        ADDR_OPA_UMAC: begin
          opa_next  = wval;
          mode_next = unsigned_accumulate_mode;
        end
        ADDR_OPA_SMAC: begin
          opa_next  = wval;
          mode_next = signed_accumulate_mode;
        end
        ADDR_OPB: begin
          opb_next   = wval;
          start_next = 1'b1;
        end
        // Software may preload the accumulator
        ADDR_RES_LO: begin
          lo_next = wval;
        end
        ADDR_RES_HI: begin
          hi_next = wval;
        end
        // Extension is read-only; other addresses not ours
        default: begin
        end
      endcase
    end
    // Read mux; unmapped addresses read zero
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_OPA_UMUL, ADDR_OPA_SMUL,
        ADDR_OPA_UMAC, ADDR_OPA_SMAC: rdata_next = opa_reg;
        ADDR_OPB:     rdata_next = opb_reg;
        ADDR_RES_LO:  rdata_next = lo_next;
        ADDR_RES_HI:  rdata_next = hi_next;
        ADDR_RES_EXT: rdata_next = ext_next;
        default:      rdata_next = RST_WORD;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opa_reg   <= RST_WORD;
      opb_reg   <= RST_WORD;
      mode_reg  <= unsigned_product_mode;
      lo_reg    <= RST_WORD;
      hi_reg    <= RST_WORD;
      ext_reg   <= RST_WORD;
      start_reg <= 1'b0;
      rdata_reg <= RST_WORD;
    end else begin
      opa_reg   <= opa_next;
      opb_reg   <= opb_next;
      mode_reg  <= mode_next;
      lo_reg    <= lo_next;
      hi_reg    <= hi_next;
      ext_reg   <= ext_next;
      start_reg <= start_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign busy  = start_reg;

  // Assertions

  property p_result_time;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_OPB) |=> ##1 !busy;
  endproperty
  a_result_time: assert property (p_result_time)
    else $error("Result not ready in time");

  property p_opa_no_start;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_OPA_UMUL) |=> !busy;
  endproperty
  a_opa_no_start: assert property (p_opa_no_start)
    else $error("Operand-one write started an operation");

  property p_opb_start;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_OPB) |=> busy;
  endproperty
  a_opb_start: assert property (p_opb_start)
    else $error("Operand-two write did not start");

  property p_mode_smac;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_OPA_SMAC) |=>
        mode_reg == signed_accumulate_mode;
  endproperty
  a_mode_smac: assert property (p_mode_smac)
    else $error("Mode not latched from address");

  property p_opa_kept;
    @(posedge clk) disable iff (!rst_n)
      (busy && !bus.wr) |=> $stable(opa_reg) && $stable(mode_reg);
  endproperty
  a_opa_kept: assert property (p_opa_kept)
    else $error("First operand lost after operation");

  property p_ext_umul;
    @(posedge clk) disable iff (!rst_n)
      (busy && mode_reg == unsigned_product_mode) |=>
        ext_reg == EXT_ZERO;
  endproperty
  a_ext_umul: assert property (p_ext_umul)
    else $error("Extension not zero after unsigned product");

  property p_ext_sign;
    @(posedge clk) disable iff (!rst_n)
      (busy && sgn) |=>
        ext_reg == ($past(sum[32]) ? EXT_ONES : EXT_ZERO);
  endproperty
  a_ext_sign: assert property (p_ext_sign)
    else $error("Extension does not show sign");

  property p_ext_carry;
    @(posedge clk) disable iff (!rst_n)
      (busy && mode_reg == unsigned_accumulate_mode) |=>
        ext_reg == {15'h0, $past(sum[32])};
  endproperty
  a_ext_carry: assert property (p_ext_carry)
    else $error("Extension does not show carry");

  property p_byte_clear;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.byte_acc && bus.addr == ADDR_OPB) |=>
        opb_reg[15:8] == 8'h00;
  endproperty
  a_byte_clear: assert property (p_byte_clear)
    else $error("Byte write left upper byte set");

  property p_lo_word;
    @(posedge clk) disable iff (!rst_n)
      (busy && !bus.wr) |=> lo_reg == $past(sum[15:0]);
  endproperty
  a_lo_word: assert property (p_lo_word)
    else $error("Low result word wrong");

  property p_hi_word;
    @(posedge clk) disable iff (!rst_n)
      (busy && !bus.wr) |=> hi_reg == $past(sum[31:16]);
  endproperty
  a_hi_word: assert property (p_hi_word)
    else $error("High result word wrong");

  property p_acc_add;
    @(posedge clk) disable iff (!rst_n)
      (busy && acc_mode && !bus.wr) |=>
        {hi_reg, lo_reg} == 32'({$past(hi_reg), $past(lo_reg)} +
                                $past(prod[31:0]));
  endproperty
  a_acc_add: assert property (p_acc_add)
    else $error("Accumulate did not add product to held result");

  property p_mode_umac;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_OPA_UMAC) |=>
        mode_reg == unsigned_accumulate_mode;
  endproperty
  a_mode_umac: assert property (p_mode_umac)
    else $error("Unsigned accumulate address did not set mode");

  property p_umul_prod;
    @(posedge clk) disable iff (!rst_n)
      (busy && mode_reg == unsigned_product_mode && !bus.wr) |=>
        {hi_reg, lo_reg} == 32'($past(opa_reg) * $past(opb_reg));
  endproperty
  a_umul_prod: assert property (p_umul_prod)
    else $error("Unsigned product wrong");

  property p_smul_prod;
    @(posedge clk) disable iff (!rst_n)
      (busy && mode_reg == signed_product_mode && !bus.wr) |=>
        {hi_reg, lo_reg} ==
          32'($signed($past(opa_reg)) * $signed($past(opb_reg)));
  endproperty
  a_smul_prod: assert property (p_smul_prod)
    else $error("Signed product wrong");

  property p_ext_ro;
    @(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_RES_EXT && !busy) |=>
        $stable(ext_reg);
  endproperty
  a_ext_ro: assert property (p_ext_ro)
    else $error("Extension word changed by a store");

endmodule : mmmac_core

//--- rtl/mmmac_pkg.sv
package mmmac_pkg;

  // Register byte addresses on the peripheral bus
  localparam logic [8:0]  ADDR_OPA_UMUL  = 9'h130;
  localparam logic [8:0]  ADDR_OPA_SMUL  = 9'h132;
  localparam logic [8:0]  ADDR_OPA_UMAC  = 9'h134;
  localparam logic [8:0]  ADDR_OPA_SMAC  = 9'h136;
  localparam logic [8:0]  ADDR_OPB       = 9'h138;
  localparam logic [8:0]  ADDR_RES_LO    = 9'h13A;
  localparam logic [8:0]  ADDR_RES_HI    = 9'h13C;
  localparam logic [8:0]  ADDR_RES_EXT   = 9'h13E;

  // Reset values (contents are unspecified; zero is our pick)
  localparam logic [15:0] RST_WORD       = 16'h0000;

  // Extension word codes
  localparam logic [15:0] EXT_ZERO       = 16'h0000;
  localparam logic [15:0] EXT_ONES       = 16'hFFFF;
  localparam logic [15:0] EXT_CARRY      = 16'h0001;

  // Field positions
  localparam int          BYTE_W         = 8;
  localparam int          SIGN_BIT       = 15;

  // Result latency budget in clock cycles after the operand-two write
  localparam int          RESULT_CYCLES  = 3;

  // Operation selected by the operand-one address
  typedef enum logic [1:0] {
    unsigned_product_mode,
    signed_product_mode,
    unsigned_accumulate_mode,
    signed_accumulate_mode
  } mmmac_mode_t;

  // One bus access from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        byte_acc;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } mmmac_bus_t;

endpackage : mmmac_pkg

//--- tb/mmmac_cpu_model.sv
`timescale 1ns/1ps
module mmmac_cpu_model
  import mmmac_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Bus toward the peripheral
  output mmmac_bus_t       bus,
  // Read data coming back
  input  wire logic [15:0] rdata
);
  // Idle at time zero so reset sees no access
  initial bus = '0;

  // Released bus: strobes drop, address and data flip, never stale
  task automatic release_bus();
    @(posedge clk);
    bus <= '{1'b0, 1'b0, 1'b0, ~bus.addr, ~bus.wdata};
  endtask : release_bus

  // One store, word or low byte
  task automatic write(input logic [8:0] a, input logic [15:0] d,
                       input logic b);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, b, a, d};
    release_bus();
  endtask : write

  // Plain load comes a whole access after the trigger store; trig_read loads in the very next cycle
  task automatic read(input logic [8:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, 1'b0, a, ~bus.wdata};
    release_bus();
    #1 d = rdata;
  endtask : read

  // Trigger store, then a direct load in the very next cycle
  task automatic trig_read(input logic [15:0] y, input logic [8:0] a,
                           output logic [15:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, 1'b0, ADDR_OPB, y};
    @(posedge clk);
    bus <= '{1'b0, 1'b1, 1'b0, a, ~y};
    release_bus();
    #1 d = rdata;
  endtask : trig_read

  // Both operands in one uninterrupted pair, so mode is never lost
  task automatic op_pair(input logic [8:0] a, input logic [15:0] x,
                         input logic [15:0] y);
    write(a, x, 1'b0);
    write(ADDR_OPB, y, 1'b0);
  endtask : op_pair
endmodule : mmmac_cpu_model

//--- tb/mmmac_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  err_total++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module mmmac_tb_top
  import mmmac_pkg::*;
;
  // Clock, reset and bus wires
  logic       clk;
  logic       rst_n;
  mmmac_bus_t bus;
  logic [15:0] rdata;
  logic       busy;
  // Score counters
  int         err_total;
  int         num_checks;

  mmmac_core i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
                    .busy(busy));
  mmmac_cpu_model i_cpu (.clk(clk), .bus(bus), .rdata(rdata));

  // Prints the counts and the verdict, then stops
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // Reads all three result words and compares them
  task automatic res_chk(input logic [15:0] lo, input logic [15:0] hi,
                         input logic [15:0] ext);
    logic [15:0] d;
    i_cpu.read(ADDR_RES_LO, d);
    `CHK("lo", lo, d)
    i_cpu.read(ADDR_RES_HI, d);
    `CHK("hi", hi, d)
    i_cpu.read(ADDR_RES_EXT, d);
    `CHK("ext", ext, d)
  endtask : res_chk

  // Preloads the accumulator through the writable result words
  task automatic preload(input logic [15:0] hi, input logic [15:0] lo);
    i_cpu.write(ADDR_RES_LO, lo, 1'b0);
    i_cpu.write(ADDR_RES_HI, hi, 1'b0);
  endtask : preload

  // Plain and signed products, sign seen in high and extension words
  task automatic t_mul();
    res_chk(RST_WORD, RST_WORD, RST_WORD);
    i_cpu.op_pair(ADDR_OPA_UMUL, 16'h1234, 16'h5678);
    res_chk(16'h0060, 16'h0626, EXT_ZERO);
    i_cpu.op_pair(ADDR_OPA_SMUL, 16'hFFFE, 16'h0003);
    res_chk(16'hFFFA, 16'hFFFF, EXT_ONES);
    i_cpu.op_pair(ADDR_OPA_SMUL, 16'h7FFF, 16'h7FFF);
    res_chk(16'h0001, 16'h3FFF, EXT_ZERO);
  endtask : t_mul

  // Busy for one cycle; a load right after the trigger sees the result
  task automatic t_fwd();
    logic [15:0] d;
    i_cpu.op_pair(ADDR_OPA_UMUL, 16'h1234, 16'h5678);
    #1;
    `CHK("busy_set", 1'b1, busy)
    i_cpu.trig_read(16'h0002, ADDR_RES_LO, d);
    `CHK("fwd_lo", 16'h2468, d)
    `CHK("busy_clr", 1'b0, busy)
    i_cpu.write(ADDR_OPA_SMUL, 16'hFFFF, 1'b0);
    i_cpu.trig_read(16'h0002, ADDR_RES_EXT, d);
    `CHK("fwd_ext", EXT_ONES, d)
  endtask : t_fwd

  // Accumulate with carry, then a repeat through operand two alone
  task automatic t_umac();
    preload(16'hFFFF, 16'hFFFF);
    i_cpu.op_pair(ADDR_OPA_UMAC, 16'h0002, 16'h0001);
    res_chk(16'h0001, 16'h0000, EXT_CARRY);
    i_cpu.write(ADDR_OPB, 16'h0001, 1'b0);
    res_chk(16'h0003, 16'h0000, EXT_ZERO);
  endtask : t_umac

  // Signed wrap both ways; extension keeps the true sign
  task automatic t_smac();
    preload(16'h8000, 16'h0000);
    i_cpu.op_pair(ADDR_OPA_SMAC, 16'hFFFF, 16'h0001);
    res_chk(16'hFFFF, 16'h7FFF, EXT_ONES);
    preload(16'h7FFF, 16'hFFFF);
    i_cpu.op_pair(ADDR_OPA_SMAC, 16'h0001, 16'h0001);
    res_chk(16'h0000, 16'h8000, EXT_ZERO);
  endtask : t_smac

  // Byte operands with junk upper lanes; operand one must not start
  task automatic t_byte();
    logic [15:0] d;
    i_cpu.write(ADDR_OPA_UMUL, 16'hAB12, 1'b1);
    res_chk(16'h0000, 16'h8000, EXT_ZERO);
    i_cpu.write(ADDR_OPB, 16'hCD34, 1'b1);
    res_chk(16'h03A8, 16'h0000, EXT_ZERO);
    i_cpu.read(ADDR_OPB, d);
    `CHK("opb_byte", 16'h0034, d)
    i_cpu.read(ADDR_OPA_SMAC, d);
    `CHK("opa_byte", 16'h0012, d)
    i_cpu.write(ADDR_RES_EXT, 16'h1234, 1'b0);
    i_cpu.read(ADDR_RES_EXT, d);
    `CHK("ext_ro", EXT_ZERO, d)
    i_cpu.read(9'h140, d);
    `CHK("unmapped", 16'h0000, d)
  endtask : t_byte

  // Free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Reset for two cycles, then every scenario in turn
  initial begin
    rst_n = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_mul();
    t_fwd();
    t_umac();
    t_smac();
    t_byte();
    close_out();
  end

  // Watchdog well beyond the 126 or so cycles the tests need
  initial begin
    #(3000 * 100);
    err_total++;
    close_out();
  end
endmodule : mmmac_tb_top
